// ===== logic/cmb_map.svh
`ifndef CMB_MAP_SVH
`define CMB_MAP_SVH
// Slot word offsets as indexes; byte address is four times the index
`define CMB_OFF_CTRL       4'h0
`define CMB_OFF_ID_UPPER   4'h2
`define CMB_OFF_ID_LOWER   4'h4
`define CMB_OFF_DATA01     4'h6
`define CMB_OFF_DATA23     4'h8
`define CMB_OFF_DATA45     4'hA
`define CMB_OFF_DATA67     4'hC
`define CMB_OFF_UNUSED     4'hE
`define CMB_SLOT_STRIDE    8'h10
`define CMB_TIMER_INDEX    12'h400
`define CMB_TIMER_ADDR     13'h1000
// Word index inside a slot (printed offset divided by two)
`define CMB_W_CTRL         3'h0
`define CMB_W_UPPER        3'h1
`define CMB_W_LOWER        3'h2
`define CMB_W_UNUSED       3'h7
// Control word fields
`define CMB_STAMP_HI       15
`define CMB_STAMP_LO       8
`define CMB_CODE_HI        7
`define CMB_CODE_LO        4
`define CMB_LEN_HI         3
`define CMB_LEN_LO         0
// Slot state codes
`define CMB_RX_INACTIVE    4'h0
`define CMB_RX_EMPTY       4'h4
`define CMB_RX_FULL        4'h2
`define CMB_RX_OVERRUN     4'h6
`define CMB_TX_NOT_READY   4'h8
`define CMB_TX_ONCE        4'hC
`define CMB_TX_ANSWER      4'hA
`define CMB_TX_ANSWER_NOW  4'hE
// Timing, length limit and response codes
`define CMB_BUSY_MAX_CYC   20
`define CMB_FILL_CYC       5'h04
`define CMB_MAX_BYTES      4'h8
`define CMB_RESP_OKAY      2'h0
`define CMB_RESP_SLVERR    2'h2
`endif

// ===== logic/cmb_pkg.sv
package cmb_pkg;
	typedef struct packed
	{
		logic        ide;
		logic        srr;
		logic        rtr;
		logic [28:0] id;
		logic [3:0]  dlc;
		logic [63:0] data;
	} cmb_frame_type;
	typedef logic [3:0] cmb_slot_type;
endpackage : cmb_pkg

// ===== logic/cmb_slot_store.sv
// Contract
// - Dominant is out_a low, out_b high
// - Inactive receive slot never stores frames
// - Empty slot becomes full after store
// - Store into full slot gives overrun unless read
// - Busy bit set while filling, under 20 cycles
// - Busy end picks full or overrun code
// - Not-ready transmit slot is never sent
// - One-shot data frame then not ready
// - Remote frame sent, slot becomes empty receive
// - Remote request turns answer slot to send
// - Answer sent once, back to answering
// - Receive length comes from frame length code
// - Length sent as code; remote sends no data
// - Eight data bytes stored and sent in order
// - Extended stamp is timer high byte
// - Identifier split 14 upper, 15 lower bits
// - Substitute bit stored as received
// - Extension bit selects slot layout
// - Extended remote bit is lower word bit 0
// - Standard lower word holds full timer stamp
// - Control word read locks slot until release
`include "cmb_map.svh"
module cmb_slot_store #(
	parameter int NUM_SLOTS = 16,
	parameter logic [4:0] FILL_CYCLES = `CMB_FILL_CYC
) (
	input  wire logic                  aclk,              // System clock, 10 MHz
	input  wire logic                  aresetn,           // Synchronous reset, active low
	input  wire logic [12:0]           s_axi_awaddr,      // Write address
	input  wire logic                  s_axi_awvalid,     // Write address valid
	output logic                       s_axi_awready,     // Write address ready
	input  wire logic [31:0]           s_axi_wdata,       // Write data
	input  wire logic [3:0]            s_axi_wstrb,       // Write strobes
	input  wire logic                  s_axi_wvalid,      // Write data valid
	output logic                       s_axi_wready,      // Write data ready
	output logic [1:0]                 s_axi_bresp,       // Write response
	output logic                       s_axi_bvalid,      // Write response valid
	input  wire logic                  s_axi_bready,      // Write response ready
	input  wire logic [12:0]           s_axi_araddr,      // Read address
	input  wire logic                  s_axi_arvalid,     // Read address valid
	output logic                       s_axi_arready,     // Read address ready
	output logic [31:0]                s_axi_rdata,       // Read data
	output logic [1:0]                 s_axi_rresp,       // Read response
	output logic                       s_axi_rvalid,      // Read data valid
	input  wire logic                  s_axi_rready,      // Read data ready
	output logic                       bus_transmit_out_a, // Transmit pin, low when dominant
	output logic                       bus_transmit_out_b, // Transmit pin, high when dominant
	input  wire logic                  bus_receive_in,    // Receive pin, low when dominant
	input  wire logic                  tx_line_dominant,  // Engine bit to drive, 1 dominant
	output logic                       rx_line_dominant,  // Synchronised line, 1 dominant
	input  wire logic                  id_start,          // Pulse: identifier field begins
	input  wire logic                  rx_store_valid,    // Pulse: matched frame to store
	input  wire cmb_pkg::cmb_slot_type rx_store_slot,     // Slot that matched
	input  wire cmb_pkg::cmb_frame_type rx_store_frame,   // Received frame
	input  wire logic                  rx_remote_valid,   // Pulse: matching remote request
	input  wire cmb_pkg::cmb_slot_type rx_remote_slot,    // Slot that the request matched
	output logic                       tx_req_valid,      // Frame offered to the engine
	output cmb_pkg::cmb_slot_type      tx_req_slot,       // Slot being sent
	output cmb_pkg::cmb_frame_type     tx_req_frame,      // Frame being sent
	output logic [3:0]                 tx_data_count,     // Data bytes to put on the line
	input  wire logic                  tx_done,           // Pulse: sent successfully
	input  wire logic                  tx_abort           // Pulse: lost, slot released
);
	import cmb_pkg::*;

	logic [15:0]    slot_mem [NUM_SLOTS][8];
	logic [15:0]    timer_reg;
	logic [15:0]    stamp_reg;
	logic           rx_sync1_reg;
	logic           rx_sync2_reg;
	logic           out_a_reg;
	logic           out_b_reg;
	logic           bvalid_reg;
	logic [1:0]     bresp_reg;
	logic           rvalid_reg;
	logic [1:0]     rresp_reg;
	logic [15:0]    rdata_reg;
	logic           lock_valid_reg;
	cmb_slot_type   lock_slot_reg;
	logic           pend_valid_reg;
	cmb_slot_type   pend_slot_reg;
	cmb_frame_type  pend_frame_reg;
	logic [15:0]    pend_stamp_reg;
	logic           fill_active_reg;
	cmb_slot_type   fill_slot_reg;
	cmb_frame_type  fill_frame_reg;
	logic [15:0]    fill_stamp_reg;
	logic [4:0]     fill_cnt_reg;
	logic           tx_active_reg;
	cmb_slot_type   tx_slot_reg;
	logic           tx_cancel_reg;
	logic [NUM_SLOTS-1:0] read_seen_reg;

	// Receive pin passes two flops before anything looks at it
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			rx_sync1_reg <= 1'b1;
			rx_sync2_reg <= 1'b1;
		end
		else
		begin
			rx_sync1_reg <= bus_receive_in;
			rx_sync2_reg <= rx_sync1_reg;
		end
	end
	assign rx_line_dominant = ~rx_sync2_reg;

	// Pins idle recessive after reset
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			out_a_reg <= 1'b1;
			out_b_reg <= 1'b0;
		end
		else
		begin
			out_a_reg <= ~tx_line_dominant;
			out_b_reg <= tx_line_dominant;
		end
	end
	assign bus_transmit_out_a = out_a_reg;
	assign bus_transmit_out_b = out_b_reg;

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			timer_reg <= 16'h0000;
			stamp_reg <= 16'h0000;
		end
		else
		begin
			timer_reg <= timer_reg + 16'h0001;
			if (id_start)
				stamp_reg <= timer_reg;
		end
	end

	// Bus decode: address and data are taken together, so write order never matters
	logic         wr_go;
	logic         rd_go;
	logic         wr_in_slots;
	logic         rd_in_slots;
	logic         rd_timer;
	cmb_slot_type wr_slot;
	cmb_slot_type rd_slot;
	logic [2:0]   wr_word;
	logic [2:0]   rd_word;
	logic [15:0]  wr_mask;
	logic         wr_ctrl;

	assign s_axi_awready = s_axi_awvalid & s_axi_wvalid & ~bvalid_reg;
	assign s_axi_wready  = s_axi_awready;
	assign s_axi_arready = ~rvalid_reg;
	assign wr_go = s_axi_awready;
	assign rd_go = s_axi_arvalid & s_axi_arready;
	assign wr_slot = s_axi_awaddr[9:6];
	assign wr_word = s_axi_awaddr[5:3];
	assign rd_slot = s_axi_araddr[9:6];
	assign rd_word = s_axi_araddr[5:3];
	assign wr_in_slots = (s_axi_awaddr[12:10] == 3'h0) && (s_axi_awaddr[2:0] == 3'h0)
		&& (32'(wr_slot) < NUM_SLOTS);
	assign rd_in_slots = (s_axi_araddr[12:10] == 3'h0) && (s_axi_araddr[2:0] == 3'h0)
		&& (32'(rd_slot) < NUM_SLOTS);
	assign rd_timer = (s_axi_araddr == `CMB_TIMER_ADDR);
	assign wr_mask = {{8{s_axi_wstrb[1]}}, {8{s_axi_wstrb[0]}}};
	assign wr_ctrl = wr_go && wr_in_slots && (wr_word == `CMB_W_CTRL);

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			bvalid_reg <= 1'b0;
			bresp_reg  <= `CMB_RESP_OKAY;
		end
		else if (wr_go)
		begin
			bvalid_reg <= 1'b1;
			bresp_reg  <= wr_in_slots ? `CMB_RESP_OKAY : `CMB_RESP_SLVERR;
		end
		else if (s_axi_bready)
			bvalid_reg <= 1'b0;
	end

	// Slot_unused_word word and timer upper lanes read as zero
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			rvalid_reg <= 1'b0;
			rresp_reg  <= `CMB_RESP_OKAY;
			rdata_reg  <= 16'h0000;
		end
		else if (rd_go)
		begin
			rvalid_reg <= 1'b1;
			rresp_reg  <= (rd_in_slots || rd_timer) ? `CMB_RESP_OKAY : `CMB_RESP_SLVERR;
			if (rd_timer)
				rdata_reg <= timer_reg;
			else if (rd_in_slots && rd_word != `CMB_W_UNUSED)
				rdata_reg <= slot_mem[rd_slot][rd_word];
			else
				rdata_reg <= 16'h0000;
		end
		else if (s_axi_rready)
			rvalid_reg <= 1'b0;
	end
	assign s_axi_bvalid = bvalid_reg;
	assign s_axi_bresp  = bresp_reg;
	assign s_axi_rvalid = rvalid_reg;
	assign s_axi_rresp  = rresp_reg;
	assign s_axi_rdata  = {16'h0000, rdata_reg};

	// Only one slot is locked; reading the timer frees it
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			lock_valid_reg <= 1'b0;
			lock_slot_reg  <= 4'h0;
		end
		else if (rd_go && rd_in_slots && rd_word == `CMB_W_CTRL)
		begin
			lock_valid_reg <= 1'b1;
			lock_slot_reg  <= rd_slot;
		end
		else if (rd_go && rd_timer)
			lock_valid_reg <= 1'b0;
	end

	// Receive path: one holding frame; a newer frame replaces it silently
	logic [3:0] pend_code;
	logic       pend_active;
	logic       pend_locked;
	logic       fill_start;
	logic       fill_end;
	logic [3:0] fill_code;
	logic [3:0] fill_final;

	assign pend_code   = slot_mem[pend_slot_reg][`CMB_W_CTRL][`CMB_CODE_HI:`CMB_CODE_LO];
	assign pend_active = (pend_code == `CMB_RX_EMPTY) || (pend_code == `CMB_RX_FULL)
		|| (pend_code == `CMB_RX_OVERRUN);
	assign pend_locked = lock_valid_reg && (lock_slot_reg == pend_slot_reg);
	assign fill_start  = pend_valid_reg && !fill_active_reg && pend_active && !pend_locked;
	assign fill_end    = fill_active_reg && (fill_cnt_reg == 5'h00);
	assign fill_code   = slot_mem[fill_slot_reg][`CMB_W_CTRL][`CMB_CODE_HI:`CMB_CODE_LO];
	assign fill_final  = (fill_code[2:1] == 2'b10 || read_seen_reg[fill_slot_reg])
		? `CMB_RX_FULL : `CMB_RX_OVERRUN;

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			pend_valid_reg <= 1'b0;
			pend_slot_reg  <= 4'h0;
			pend_frame_reg <= '0;
			pend_stamp_reg <= 16'h0000;
		end
		else if (rx_store_valid)
		begin
			pend_valid_reg <= 1'b1;
			pend_slot_reg  <= rx_store_slot;
			pend_frame_reg <= rx_store_frame;
			pend_stamp_reg <= stamp_reg;
		end
		else if (fill_start || (pend_valid_reg && !pend_active))
			pend_valid_reg <= 1'b0;
	end

	// Host write of the control word stops a fill in progress
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			fill_active_reg <= 1'b0;
			fill_slot_reg   <= 4'h0;
			fill_frame_reg  <= '0;
			fill_stamp_reg  <= 16'h0000;
			fill_cnt_reg    <= 5'h00;
		end
		else if (fill_start)
		begin
			fill_active_reg <= 1'b1;
			fill_slot_reg   <= pend_slot_reg;
			fill_frame_reg  <= pend_frame_reg;
			fill_stamp_reg  <= pend_stamp_reg;
			fill_cnt_reg    <= FILL_CYCLES;
		end
		else if (fill_end || (wr_ctrl && wr_slot == fill_slot_reg))
			fill_active_reg <= 1'b0;
		else if (fill_active_reg)
			fill_cnt_reg <= fill_cnt_reg - 5'h01;
	end

	// Transmit path: lowest ready slot wins
	logic         tx_found;
	cmb_slot_type tx_pick;
	logic [15:0]  tx_ctrl;
	logic [15:0]  tx_upper;
	logic [15:0]  tx_lower;
	logic [3:0]   tx_code;
	logic         tx_rtr;

	always_comb
	begin
		tx_found = 1'b0;
		tx_pick  = 4'h0;
		for (int s = NUM_SLOTS - 1; s >= 0; s--)
		begin
			if (slot_mem[s][`CMB_W_CTRL][`CMB_CODE_HI:`CMB_CODE_LO] == `CMB_TX_ONCE
				|| slot_mem[s][`CMB_W_CTRL][`CMB_CODE_HI:`CMB_CODE_LO] == `CMB_TX_ANSWER_NOW)
			begin
				tx_found = 1'b1;
				tx_pick  = s[3:0];
			end
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			tx_active_reg <= 1'b0;
			tx_slot_reg   <= 4'h0;
			tx_cancel_reg <= 1'b0;
		end
		else if (!tx_active_reg)
		begin
			tx_active_reg <= tx_found;
			tx_slot_reg   <= tx_pick;
			tx_cancel_reg <= 1'b0;
		end
		else if (tx_done || tx_abort)
			tx_active_reg <= 1'b0;
		else if (wr_ctrl && wr_slot == tx_slot_reg)
			tx_cancel_reg <= 1'b1;
	end

	assign tx_ctrl  = slot_mem[tx_slot_reg][`CMB_W_CTRL];
	assign tx_upper = slot_mem[tx_slot_reg][`CMB_W_UPPER];
	assign tx_lower = slot_mem[tx_slot_reg][`CMB_W_LOWER];
	assign tx_code  = tx_ctrl[`CMB_CODE_HI:`CMB_CODE_LO];
	assign tx_rtr   = tx_upper[3] ? tx_lower[0] : tx_upper[4];

	always_comb
	begin
		tx_req_frame.ide  = tx_upper[3];
		tx_req_frame.srr  = tx_upper[3] & tx_upper[4];
		tx_req_frame.rtr  = tx_rtr;
		tx_req_frame.id   = tx_upper[3] ? {tx_upper[15:5], tx_upper[2:0], tx_lower[15:1]}
			: {tx_upper[15:5], 18'h00000};
		tx_req_frame.dlc  = tx_ctrl[`CMB_LEN_HI:`CMB_LEN_LO];
		tx_req_frame.data = {slot_mem[tx_slot_reg][3], slot_mem[tx_slot_reg][4],
			slot_mem[tx_slot_reg][5], slot_mem[tx_slot_reg][6]};
	end
	assign tx_req_valid  = tx_active_reg;
	assign tx_req_slot   = tx_slot_reg;
	// Oversized lengths still send at most eight bytes
	assign tx_data_count = tx_rtr ? 4'h0 : (tx_ctrl[3] ? `CMB_MAX_BYTES : tx_ctrl[3:0]);

	// Received frame laid out by format
	logic [15:0] fill_upper;
	logic [15:0] fill_lower;
	assign fill_upper = fill_frame_reg.ide
		? {fill_frame_reg.id[28:18], fill_frame_reg.srr, 1'b1, fill_frame_reg.id[17:15]}
		: {fill_frame_reg.id[28:18], fill_frame_reg.rtr, 4'h0};
	assign fill_lower = fill_frame_reg.ide
		? {fill_frame_reg.id[14:0], fill_frame_reg.rtr}
		: fill_stamp_reg;

	// Slot storage; the host write comes last so it overrides device updates
	for (genvar g = 0; g < NUM_SLOTS; g++)
	begin : g_slot
		logic tx_here;
		logic fill_here;
		logic host_ctrl;
		assign tx_here   = tx_active_reg && tx_done && !tx_cancel_reg && tx_slot_reg == g;
		assign fill_here = fill_active_reg && fill_slot_reg == g;
		assign host_ctrl = wr_ctrl && wr_slot == g;

		always_ff @(posedge aclk)
		begin
			if (!aresetn)
				read_seen_reg[g] <= 1'b0;
			else if (rd_go && rd_in_slots && rd_word == `CMB_W_CTRL && rd_slot == g)
				read_seen_reg[g] <= 1'b1;
			else if (fill_here && fill_end)
				read_seen_reg[g] <= 1'b0;
		end

		always_ff @(posedge aclk)
		begin
			if (!aresetn)
			begin
				for (int w = 0; w < 8; w++)
					slot_mem[g][w] <= 16'h0000;
			end
			else
			begin
				if (tx_here)
				begin
					slot_mem[g][0][15:8] <= stamp_reg[15:8];
					if (!tx_upper[3])
						slot_mem[g][2] <= stamp_reg;
					if (tx_code == `CMB_TX_ANSWER_NOW)
						slot_mem[g][0][7:4] <= `CMB_TX_ANSWER;
					else if (tx_rtr)
						slot_mem[g][0][7:4] <= `CMB_RX_EMPTY;
					else
						slot_mem[g][0][7:4] <= `CMB_TX_NOT_READY;
				end
				if (rx_remote_valid && rx_remote_slot == g
					&& slot_mem[g][0][7:4] == `CMB_TX_ANSWER)
					slot_mem[g][0][7:4] <= `CMB_TX_ANSWER_NOW;
				if (fill_start && pend_slot_reg == g)
					slot_mem[g][0][4] <= 1'b1;
				if (fill_here && fill_end)
				begin
					slot_mem[g][0] <= {fill_stamp_reg[15:8], fill_final,
						fill_frame_reg.dlc};
					slot_mem[g][1] <= fill_upper;
					slot_mem[g][2] <= fill_lower;
					for (int w = 0; w < 4; w++)
						slot_mem[g][3 + w] <= fill_frame_reg.data[63 - 16 * w -: 16];
				end
				if (wr_go && wr_in_slots && wr_slot == g && wr_word != `CMB_W_UNUSED)
					slot_mem[g][wr_word] <= (slot_mem[g][wr_word] & ~wr_mask)
						| (s_axi_wdata[15:0] & wr_mask);
			end
		end
	end

	// Checks
	logic [3:0] fill_slot_code;
	logic       fill_host_hit;
	assign fill_slot_code = slot_mem[fill_slot_reg][0][7:4];
	assign fill_host_hit  = wr_ctrl && wr_slot == fill_slot_reg;

	pins_dominant_a: assert property (@(posedge aclk) disable iff (!aresetn)
		##1 (bus_transmit_out_a != bus_transmit_out_b)
		&& (bus_transmit_out_b == $past(tx_line_dominant)))
		else $error("transmit pins not complementary to engine bit");
	store_active_a: assert property (@(posedge aclk) disable iff (!aresetn)
		pend_valid_reg && pend_code == `CMB_RX_INACTIVE
		&& !(wr_ctrl && wr_slot == pend_slot_reg)
		|=> slot_mem[$past(pend_slot_reg)][0][7:4] == `CMB_RX_INACTIVE)
		else $error("inactive slot took part in a store");
	busy_bound_a: assert property (@(posedge aclk) disable iff (!aresetn)
		fill_start |=> fill_slot_code[0] ##[0:19] !fill_active_reg)
		else $error("busy fill not set or not ended in time");
	empty_full_a: assert property (@(posedge aclk) disable iff (!aresetn)
		fill_end && !fill_host_hit && fill_code[2:1] == 2'b10
		|=> slot_mem[$past(fill_slot_reg)][0][7:4] == `CMB_RX_FULL)
		else $error("empty slot did not become full");
	overrun_code_a: assert property (@(posedge aclk) disable iff (!aresetn)
		fill_end && !fill_host_hit && fill_code[2:1] != 2'b10
		&& !read_seen_reg[fill_slot_reg]
		|=> slot_mem[$past(fill_slot_reg)][0][7:4] == `CMB_RX_OVERRUN)
		else $error("unread full slot not marked overrun");
	lock_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
		lock_valid_reg && !fill_active_reg && !(wr_ctrl && wr_slot == lock_slot_reg)
		|=> slot_mem[$past(lock_slot_reg)][0][4] == $past(slot_mem[lock_slot_reg][0][4]))
		else $error("locked slot started a fill");
	tx_ready_a: assert property (@(posedge aclk) disable iff (!aresetn)
		$rose(tx_req_valid) |-> tx_code inside {`CMB_TX_ONCE, `CMB_TX_ANSWER_NOW})
		else $error("slot offered while not ready");
	once_done_a: assert property (@(posedge aclk) disable iff (!aresetn)
		tx_active_reg && tx_done && !tx_cancel_reg && tx_code == `CMB_TX_ONCE && !tx_rtr
		&& !(wr_ctrl && wr_slot == tx_slot_reg)
		|=> slot_mem[$past(tx_slot_reg)][0][7:4] == `CMB_TX_NOT_READY)
		else $error("one-shot data slot not returned to not ready");
	remote_empty_a: assert property (@(posedge aclk) disable iff (!aresetn)
		tx_active_reg && tx_done && !tx_cancel_reg && tx_code == `CMB_TX_ONCE && tx_rtr
		&& !(wr_ctrl && wr_slot == tx_slot_reg)
		|=> slot_mem[$past(tx_slot_reg)][0][7:4] == `CMB_RX_EMPTY)
		else $error("remote slot did not become empty receive");
	remote_len_a: assert property (@(posedge aclk) disable iff (!aresetn)
		tx_req_valid && tx_rtr |-> tx_data_count == 4'h0)
		else $error("remote frame offered with data");

	fill_seen_c: cover property (@(posedge aclk) disable iff (!aresetn) fill_end);
	overrun_seen_c: cover property (@(posedge aclk) disable iff (!aresetn)
		fill_end && fill_final == `CMB_RX_OVERRUN);
	answer_seen_c: cover property (@(posedge aclk) disable iff (!aresetn)
		tx_done && tx_code == `CMB_TX_ANSWER_NOW);
endmodule : cmb_slot_store

// ===== tb/cmb_bus_model.sv
module cmb_bus_model
(
	input  wire logic aclk,       // System clock
	input  wire logic out_a,      // Device transmit pin a
	input  wire logic out_b,      // Device transmit pin b
	output logic      receive_in, // Device receive pin
	input  wire logic req_valid,  // Frame offered by the device
	input  wire logic slow,       // Answer late instead of promptly
	output logic      done        // Success pulse, one cycle
);
	timeunit 1ns;
	timeprecision 1ns;
	int cnt = 0;
	// The transceiver echoes our own bits; dominant only when a is low and b high
	assign receive_in = out_a | !out_b;
	initial done = 1'b0;
	always @(posedge aclk)
	begin
		if (!req_valid)
		begin
			cnt  <= 0;
			done <= 1'b0;
		end
		else
		begin
			cnt  <= cnt + 1;
			done <= (cnt == (slow ? 12 : 2));
		end
	end
endmodule : cmb_bus_model

// ===== tb/can_message_buffer_codes_bench.sv
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin error_cnt++; \
	$display("[FAIL] %0t got %h want %h", $time, a, b); end end
module can_message_buffer_codes_bench;
	timeunit 1ns;
	timeprecision 1ns;
	import cmb_pkg::*;
	logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, arvalid = 0, slow = 0;
	logic tx_line_dominant = 0, id_start = 0, rx_store_valid = 0, rx_remote_valid = 0;
	logic [12:0] awaddr = '0, araddr = '0;
	logic [31:0] wdata = '0, rdata, rv, c;
	logic [1:0] bresp, rresp, rr;
	logic awready, wready, bvalid, arready, rvalid, out_a, out_b, rx_in, rx_dom;
	logic tx_req_valid, tx_done;
	cmb_slot_type rx_store_slot = '0, rx_remote_slot = '0, tx_req_slot;
	cmb_frame_type rx_store_frame = '0, tx_req_frame, f;
	logic [3:0] tx_data_count;
	int error_cnt = 0, cmp_count = 0, n, i, w, seed_v, tmr = 0;
	logic [15:0] stamp_exp = 16'h0000;
	always #50 aclk = ~aclk;
	// Free-running timer model, cleared while reset is sampled low
	always @(posedge aclk) tmr <= aresetn ? tmr + 1 : 0;
	cmb_slot_store u_cmb_slot_store (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
		.s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(1'b1),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(1'b1),
		.bus_transmit_out_a(out_a), .bus_transmit_out_b(out_b), .bus_receive_in(rx_in),
		.tx_line_dominant(tx_line_dominant), .rx_line_dominant(rx_dom), .id_start(id_start),
		.rx_store_valid(rx_store_valid), .rx_store_slot(rx_store_slot),
		.rx_store_frame(rx_store_frame), .rx_remote_valid(rx_remote_valid),
		.rx_remote_slot(rx_remote_slot), .tx_req_valid(tx_req_valid), .tx_req_slot(tx_req_slot),
		.tx_req_frame(tx_req_frame), .tx_data_count(tx_data_count), .tx_done(tx_done),
		.tx_abort(1'b0));
	cmb_bus_model u_cmb_bus_model (.aclk(aclk), .out_a(out_a), .out_b(out_b),
		.receive_in(rx_in), .req_valid(tx_req_valid), .slow(slow), .done(tx_done));
	task finish_test;
		if (error_cnt == 0 && cmp_count > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : finish_test
	task tmo;
		if (n >= 200)
		begin
			error_cnt++;
			finish_test;
		end
	endtask : tmo
	// Word w of slot s sits at byte 64*s + 8*w (printed offset times four)
	task wr(input int s, input int w, input logic [15:0] d);
		awaddr  <= 13'(64 * s + 8 * w);
		wdata   <= {16'h0000, d};
		awvalid <= 1'b1;
		wvalid  <= 1'b1;
		for (n = 0; n < 200; n++) begin @(posedge aclk); if (awready && wready) break; end
		tmo;
		awvalid <= 1'b0;
		wvalid  <= 1'b0;
		for (n = 0; n < 200; n++) begin @(posedge aclk); if (bvalid) break; end
		tmo;
		`CHK(bresp, 2'h0)
	endtask : wr
	task rd(input int s, input int w);
		araddr  <= 13'(64 * s + 8 * w);
		arvalid <= 1'b1;
		for (n = 0; n < 200; n++) begin @(posedge aclk); if (arready) break; end
		tmo;
		arvalid <= 1'b0;
		for (n = 0; n < 200; n++) begin @(posedge aclk); if (rvalid) break; end
		tmo;
		rv = rdata;
		rr = rresp;
	endtask : rd
	task st(input int s, input cmb_frame_type fr);
		id_start <= 1'b1;
		@(posedge aclk);
		stamp_exp = tmr[15:0];
		id_start       <= 1'b0;
		rx_store_slot  <= 4'(s);
		rx_store_frame <= fr;
		rx_store_valid <= 1'b1;
		@(posedge aclk);
		rx_store_valid <= 1'b0;
		repeat (10) @(posedge aclk);
	endtask : st
	task chkrx(input int s, input cmb_frame_type fr, input logic [3:0] code);
		rd(s, 0);
		`CHK(rv[7:0], {code, fr.dlc})
		`CHK(rv[15:8], stamp_exp[15:8])
		rd(s, 1);
		`CHK(rv[15:0], {fr.id[28:18], fr.srr, 1'b1, fr.id[17:15]})
		rd(s, 2);
		`CHK(rv[15:0], {fr.id[14:0], fr.rtr})
		for (w = 3; w < 7; w++) begin rd(s, w); `CHK(rv[15:0], fr.data[111 - 16 * w -: 16]) end
	endtask : chkrx
	task txw(input int s, input cmb_frame_type fr, input logic [3:0] cnt);
		for (n = 0; n < 200; n++) begin @(posedge aclk); if (tx_req_valid) break; end
		tmo;
		`CHK(tx_req_slot, 4'(s))
		`CHK(tx_data_count, cnt)
		`CHK({tx_req_frame.ide, tx_req_frame.srr, tx_req_frame.dlc}, {fr.ide, fr.ide, fr.dlc})
		`CHK({tx_req_frame.id[28:18], tx_req_frame.rtr}, {fr.id[28:18], fr.rtr})
		if (cnt != 0) `CHK(tx_req_frame.data[63:48], fr.data[63:48])
		for (n = 0; n < 200; n++) begin @(posedge aclk); if (!tx_req_valid) break; end
		tmo;
	endtask : txw
	function automatic cmb_frame_type rnd();
		logic [127:0] r = {$urandom, $urandom, $urandom, $urandom};
		rnd = r[99:0];
		rnd.ide = 1'b1;
		rnd.dlc = 4'($urandom_range(8));
	endfunction : rnd
	task wrtx(input int s, input cmb_frame_type fr, input logic [3:0] code);
		wr(s, 0, 16'h0080);
		wr(s, 1, fr.ide ? {fr.id[28:18], 2'b11, fr.id[17:15]} : {fr.id[28:18], fr.rtr, 4'h0});
		wr(s, 2, {fr.id[14:0], fr.rtr});
		for (w = 3; w < 7; w++) wr(s, w, fr.data[111 - 16 * w -: 16]);
		wr(s, 0, {8'h00, code, fr.dlc});
	endtask : wrtx
	initial
	begin
		seed_v = $urandom(32'hE6E898DA);
		repeat (6) @(posedge aclk);
		aresetn <= 1'b1;
		for (i = 0; i < 2; i++)
		begin
			tx_line_dominant <= i[0];
			repeat (4) @(posedge aclk);
			`CHK({out_a, out_b, rx_dom}, {!i[0], i[0], i[0]})
		end
		f = rnd();
		st(2, f);
		rd(2, 0);
		`CHK(rv, 32'h0)
		wr(1, 0, 16'h0000);
		wr(1, 0, 16'h0040);
		st(1, f);
		chkrx(1, f, 4'h2);
		rd(64, 0);
		st(1, rnd());
		f = rnd();
		st(1, f);
		chkrx(1, f, 4'h6);
		c = {16'h0000, f.id[14:0], f.rtr};
		f = rnd();
		st(1, f);
		rd(1, 2);
		`CHK(rv, c)
		rd(64, 0);
		repeat (10) @(posedge aclk);
		chkrx(1, f, 4'h2);
		for (i = 0; i < 2; i++)
		begin
			f = rnd();
			f.rtr = i[0];
			f.ide = !i[0];
			f.dlc = i ? 4'h5 : 4'hB;
			wrtx(3 + i, f, 4'hC);
			txw(3 + i, f, i ? 4'h0 : 4'h8);
			rd(3 + i, 0);
			c = rv;
			`CHK(c[7:4], i ? 4'h4 : 4'h8)
			`CHK(c[15:8], stamp_exp[15:8])
			rd(3 + i, 2);
			if (i) `CHK(rv[15:0], stamp_exp)
		end
		slow <= 1'b1;
		wr(6, 0, 16'h0084);
		f = rnd();
		f.dlc = 4'h4;
		f.rtr = 1'b0;
		wrtx(5, f, 4'hA);
		repeat (8) @(posedge aclk);
		`CHK(tx_req_valid, 1'b0)
		rx_remote_slot  <= 4'h5;
		rx_remote_valid <= 1'b1;
		@(posedge aclk);
		rx_remote_valid <= 1'b0;
		txw(5, f, 4'h4);
		rd(5, 0);
		`CHK(rv[7:4], 4'hA)
		rd(96, 0);
		`CHK(rr, 2'h2)
		finish_test;
	end
endmodule : can_message_buffer_codes_bench
